// ---- hdl/pag_pkg.sv ----
/*
  Constants shared by the pager alert generator: register offsets, setup
  field positions, reset values, timing figures and standard patterns.
  Assumes a 10 MHz decoder clock; counts are derived from it here.
*/
package pag_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS      = 100;
  localparam int SLOT_TIME_NS       = 62_500_000;   // One cadence slot, 62.5 ms
  localparam int SLOT_CYCLES        = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam int CLK_HZ             = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int VIB_PULSE_HZ       = 25;           // Pulsed vibrator rate
  localparam int VIB_HALF_CYCLES    = CLK_HZ / (2 * VIB_PULSE_HZ);
  localparam int WARBLE_HZ          = 16;           // Warble modulation rate
  localparam int WARBLE_HALF_CYCLES = CLK_HZ / (2 * WARBLE_HZ);
  localparam int TONE_UPPER_HZ      = 4000;         // Plain default tone pitch
  localparam int TONE_LOWER_HZ      = 3200;         // Alternate warble tone pitch
  localparam int TONE_UPPER_HALF    = CLK_HZ / (2 * TONE_UPPER_HZ);
  localparam int TONE_LOWER_HALF    = CLK_HZ / (2 * TONE_LOWER_HZ);
  localparam int SLOT_TIME_US       = SLOT_TIME_NS / 1000;
  localparam int STD_LOW_TIME_MS    = 4000;         // Low level part of alert
  localparam int STD_TOTAL_TIME_MS  = 16000;        // Whole standard alert
  localparam int STD_LOW_SLOTS      = STD_LOW_TIME_MS * 1000 / SLOT_TIME_US;
  localparam int STD_TOTAL_SLOTS    = STD_TOTAL_TIME_MS * 1000 / SLOT_TIME_US;
  localparam int DIV_W              = 20;           // Divider counter width
  localparam int STD_CNT_W          = 9;            // Standard slot counter

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_PATTERN_SLOTS = 8'h03;
  localparam logic [7:0] ADDR_SETUP         = 8'h04;
  localparam logic [7:0] ADDR_STATUS        = 8'h0B;
  localparam logic [7:0] RESET_PATTERN      = 8'h00;
  localparam logic [7:0] RESET_SETUP        = 8'h00;
  localparam logic [7:0] READ_ZERO          = 8'h00;

  // ==========================================================================
  // Setup register fields
  localparam int SETUP_STD     = 0;  // Standard pattern instead of cadence
  localparam int SETUP_LEVEL   = 1;  // High level acoustic, steady vibrator
  localparam int SETUP_WARBLE  = 2;
  localparam int SETUP_TONE_EN = 3;
  localparam int SETUP_VIB_EN  = 4;
  localparam int SETUP_LED_EN  = 5;
  localparam int SETUP_CT_LO   = 6;  // Call type code, two bits
  localparam int SETUP_CT_HI   = 7;
  localparam logic [5:0] AUTO_SETUP_LOW = 6'h39;  // All enables, std, low level

  // ==========================================================================
  // Status register fields
  localparam int STAT_LAST_SLOT = 0;
  localparam int STAT_TIMEOUT   = 1;
  localparam int STAT_STD_RUN   = 2;
  localparam int STAT_AUTO      = 3;
  localparam int STAT_POS_LO    = 4;

  // ==========================================================================
  // Cadence position and standard slot patterns, first slot in the MSB
  localparam logic [2:0] POS_FIRST = 3'h7;
  localparam logic [2:0] POS_LAST  = 3'h0;
  localparam logic [7:0] STD_PATTERN_CT0 = 8'hEE;
  localparam logic [7:0] STD_PATTERN_CT1 = 8'hCC;
  localparam logic [7:0] STD_PATTERN_CT2 = 8'hAA;
  localparam logic [7:0] STD_PATTERN_CT3 = 8'hF0;

endpackage : pag_pkg

// ---- hdl/pag_tick.sv ----
/*
  Programmable tick divider: a one-cycle pulse every 'period' clocks while
  'run' is high. Assumes a single clock; run low restarts the count.
*/
`timescale 1ns/10ps
`default_nettype none

module pag_tick #(
  parameter int W = 20
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Control
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  // Result
  output logic              tick
);

  logic [W-1:0] count;

  // ==========================================================================
  // Counter; idle restart keeps the first tick a full period away
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (!run || tick) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  // Pulse on the last count of the period
  assign tick = run && (count == period - 1'b1);

endmodule : pag_tick

`default_nettype wire

// ---- hdl/pag_alert_top.sv ----
/*
  Pager alert generator: setup and slot pattern registers, cadence rotation,
  standard call-type alerts, warble, level, direct alert and tone outputs.
  Assumes a host on a simple strobe port and a call decoder that pulses
  callReceived with the call type code beside it.
*/
// The address-and-strobe port was chosen for this implementation.
// Overview of operation
// - Setup bit 0 picks cadence or standard pattern
// - Level bit: low tone/pulsed vibrator or high/steady
// - Warble bit: 16 Hz LED blink, alternating tones
// - Each transducer driven only with its enable
// - Setup bits 7:6 give call type code
// - Each cadence bit is a 62.5 ms slot
// - Rotate cadence bit 7 to 0, repeating
// - Interrupt when last cadence slot begins
// - Zero cadence register stops cadence alerts
// - Low tone output in counter phase to high
// - Standard alert: 4 s low then 12 s high
// - Interrupt when standard alert time ends
// - Level change acts at once; host avoids glitches
// - Vibrator on through standard or nonzero cadence
// - LED follows pattern, ignores level bit
// - Direct alert input overrides pattern; enables still apply
// - Standard alert pauses cadence, then resumes it
// - Outputs clocked; one extra clock from idle
// - Tone finishes its cycle after direct alert drops
// - Clearing bit 0 cancels standard alert; reset cancels all
// - Auto alert on call loads standard setup
// - Auto alert clears setup bit 0 when done
`timescale 1ns/10ps
`default_nettype none

module pag_alert_top #(
  parameter logic [19:0] SLOT_CYCLES     = 20'(pag_pkg::SLOT_CYCLES),
  parameter logic [19:0] VIB_HALF        = 20'(pag_pkg::VIB_HALF_CYCLES),
  parameter logic [19:0] WARBLE_HALF     = 20'(pag_pkg::WARBLE_HALF_CYCLES),
  parameter logic [19:0] TONE_UPPER_HALF = 20'(pag_pkg::TONE_UPPER_HALF),
  parameter logic [19:0] TONE_LOWER_HALF = 20'(pag_pkg::TONE_LOWER_HALF)
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // Decoder side
  input  wire logic       callReceived,
  input  wire logic [1:0] callTypeCode,
  input  wire logic       autoAlertEn,
  input  wire logic       directAlertIn,
  // Transducers
  output logic            toneHighOut,
  output logic            toneLowOut,
  output logic            toneLowOeN,
  output logic            vibratorOut,
  output logic            ledOut,
  // Event to host
  output logic            alertIrq
);

  logic [7:0] patternSlots;
  logic [7:0] setup;
  logic       autoFlag;
  logic       directMeta;
  logic       directSync;
  logic [2:0] cadPos;
  logic [8:0] stdSlotCnt;
  logic       stdDone;
  logic       runningQ;
  logic       toneRun;
  logic       tonePhase;
  logic       vibPhase;
  logic       warblePhase;
  logic       lastSlotFlag;
  logic       timeoutFlag;
  logic       slotTick;
  logic       vibTick;
  logic       warbleTick;
  logic       toneTick;
  logic       toneLowDrive;

  logic       wrSetup;
  logic       rdStatus;
  logic       stdMode;
  logic       cadRun;
  logic       running;
  logic       gate;
  logic       patBit;
  logic       stdBit;
  logic [7:0] stdPattern;
  logic       highLvl;
  logic       acousticReq;
  logic       vibReq;
  logic       stdEnd;
  logic       cadLastStart;
  logic [19:0] toneHalf;

  // ==========================================================================
  // Register writes, automatic alert load and self clear
  assign wrSetup  = regWr && (regAddr == pag_pkg::ADDR_SETUP);
  assign rdStatus = regRd && (regAddr == pag_pkg::ADDR_STATUS);

  // Pattern register; zero halts cadence alerts
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      patternSlots <= pag_pkg::RESET_PATTERN;
    end else if (regWr && regAddr == pag_pkg::ADDR_PATTERN_SLOTS) begin
      patternSlots <= regWdata;
    end
  end

  // Setup register; a call with auto alerts replaces host settings
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      setup    <= pag_pkg::RESET_SETUP;
      autoFlag <= 1'b0;
    end else if (callReceived && autoAlertEn) begin
      setup    <= {callTypeCode, pag_pkg::AUTO_SETUP_LOW};
      autoFlag <= 1'b1;
    end else if (wrSetup) begin
      setup    <= regWdata;
      autoFlag <= 1'b0;
    end else if (stdEnd && autoFlag) begin
      setup[pag_pkg::SETUP_STD] <= 1'b0;
      autoFlag <= 1'b0;
    end
  end

  // ==========================================================================
  // Direct alert input, two flop synchroniser
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      directMeta <= 1'b0;
      directSync <= 1'b0;
    end else begin
      directMeta <= directAlertIn;
      directSync <= directMeta;
    end
  end

  // ==========================================================================
  // Alert sources and their priority
  assign stdMode = setup[pag_pkg::SETUP_STD] && !stdDone;
  assign cadRun  = (patternSlots != pag_pkg::RESET_PATTERN) && !stdMode;
  assign running = stdMode || cadRun || directSync;

  // Standard pattern per call type code
  always_comb begin
    case (setup[pag_pkg::SETUP_CT_HI:pag_pkg::SETUP_CT_LO])
      2'h0:    stdPattern = pag_pkg::STD_PATTERN_CT0;
      2'h1:    stdPattern = pag_pkg::STD_PATTERN_CT1;
      2'h2:    stdPattern = pag_pkg::STD_PATTERN_CT2;
      default: stdPattern = pag_pkg::STD_PATTERN_CT3;
    endcase
  end

  assign stdBit = stdPattern[~stdSlotCnt[2:0]];

  // Direct input first, then standard, then cadence
  assign patBit = directSync ? 1'b1 :
                  stdMode    ? stdBit :
                  cadRun     ? patternSlots[cadPos] : 1'b0;

  // Level: setup bit, or second part of a standard alert
  assign highLvl = setup[pag_pkg::SETUP_LEVEL] ||
                   (stdMode && stdSlotCnt >= 9'(pag_pkg::STD_LOW_SLOTS));

  // Outputs wait one clock after an idle spell
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      runningQ <= 1'b0;
    end else begin
      runningQ <= running;
    end
  end

  assign gate        = running && runningQ;
  assign acousticReq = gate && setup[pag_pkg::SETUP_TONE_EN] && patBit;
  assign vibReq      = gate && setup[pag_pkg::SETUP_VIB_EN];

  // ==========================================================================
  // Dividers: slot timing, vibrator pulse, warble and tone pitch
  assign toneHalf = (setup[pag_pkg::SETUP_WARBLE] && warblePhase) ?
                    TONE_LOWER_HALF : TONE_UPPER_HALF;

  pag_tick #(.W(pag_pkg::DIV_W)) u_slot (
    .clk    (clk),
    .resetn (resetn),
    .run    (stdMode || cadRun),
    .period (SLOT_CYCLES),
    .tick   (slotTick)
  );

  pag_tick #(.W(pag_pkg::DIV_W)) u_vib (
    .clk    (clk),
    .resetn (resetn),
    .run    (vibReq),
    .period (VIB_HALF),
    .tick   (vibTick)
  );

  pag_tick #(.W(pag_pkg::DIV_W)) u_warble (
    .clk    (clk),
    .resetn (resetn),
    .run    (gate || toneRun),
    .period (WARBLE_HALF),
    .tick   (warbleTick)
  );

  pag_tick #(.W(pag_pkg::DIV_W)) u_tone (
    .clk    (clk),
    .resetn (resetn),
    .run    (toneRun),
    .period (toneHalf),
    .tick   (toneTick)
  );

  // ==========================================================================
  // Cadence position; held while a standard alert runs
  assign cadLastStart = cadRun && slotTick && (cadPos == pag_pkg::POS_LAST + 3'h1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cadPos <= pag_pkg::POS_FIRST;
    end else if (patternSlots == pag_pkg::RESET_PATTERN) begin
      cadPos <= pag_pkg::POS_FIRST;
    end else if (cadRun && slotTick) begin
      cadPos <= cadPos - 3'h1;
    end
  end

  // Standard alert slot counter; cleared by cancel or new setup
  assign stdEnd = stdMode && slotTick &&
                  (stdSlotCnt == 9'(pag_pkg::STD_TOTAL_SLOTS - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stdSlotCnt <= '0;
      stdDone    <= 1'b0;
    end else if (!setup[pag_pkg::SETUP_STD] || wrSetup || (callReceived && autoAlertEn)) begin
      stdSlotCnt <= '0;
      stdDone    <= 1'b0;
    end else if (stdEnd) begin
      stdSlotCnt <= '0;
      stdDone    <= 1'b1;
    end else if (stdMode && slotTick) begin
      stdSlotCnt <= stdSlotCnt + 9'h001;
    end
  end

  // ==========================================================================
  // Modulation phases
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vibPhase <= 1'b0;
    end else if (!vibReq) begin
      vibPhase <= 1'b0;
    end else if (vibTick) begin
      vibPhase <= ~vibPhase;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      warblePhase <= 1'b0;
    end else if (!(gate || toneRun)) begin
      warblePhase <= 1'b0;
    end else if (warbleTick) begin
      warblePhase <= ~warblePhase;
    end
  end

  // Tone keeps running until its current cycle completes, so no clipped pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      toneRun   <= 1'b0;
      tonePhase <= 1'b0;
    end else if (acousticReq) begin
      toneRun   <= 1'b1;
      tonePhase <= toneTick ? ~tonePhase : tonePhase;
    end else if (toneRun && toneTick) begin
      toneRun   <= !tonePhase;
      tonePhase <= ~tonePhase;
    end
  end

  // ==========================================================================
  // Registered transducer drive
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      toneHighOut  <= 1'b0;
      toneLowDrive <= 1'b0;
      vibratorOut  <= 1'b0;
      ledOut       <= 1'b0;
    end else begin
      toneHighOut  <= toneRun && highLvl && tonePhase;
      toneLowDrive <= toneRun && !tonePhase;
      vibratorOut  <= vibReq && (setup[pag_pkg::SETUP_LEVEL] || vibPhase);
      ledOut       <= gate && setup[pag_pkg::SETUP_LED_EN] && patBit &&
                      (!setup[pag_pkg::SETUP_WARBLE] || warblePhase);
    end
  end

  // Open drain: pin pulled low while enable is low
  assign toneLowOut = 1'b0;
  assign toneLowOeN = !toneLowDrive;

  // ==========================================================================
  // Host event and status readback; a new event beats a clearing read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alertIrq     <= 1'b0;
      lastSlotFlag <= 1'b0;
      timeoutFlag  <= 1'b0;
    end else begin
      alertIrq     <= cadLastStart || stdEnd;
      lastSlotFlag <= cadLastStart || (lastSlotFlag && !rdStatus);
      timeoutFlag  <= stdEnd || (timeoutFlag && !rdStatus);
    end
  end

  // Read data one cycle after the strobe; write only registers read as zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= pag_pkg::READ_ZERO;
    end else if (rdStatus) begin
      regRdata <= pag_pkg::READ_ZERO;
      regRdata[pag_pkg::STAT_LAST_SLOT] <= lastSlotFlag;
      regRdata[pag_pkg::STAT_TIMEOUT]   <= timeoutFlag;
      regRdata[pag_pkg::STAT_STD_RUN]   <= stdMode;
      regRdata[pag_pkg::STAT_AUTO]      <= autoFlag;
      regRdata[pag_pkg::STAT_POS_LO +: 3] <= cadPos;
    end else begin
      regRdata <= pag_pkg::READ_ZERO;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_idle_rise;
    !running ##1 running;
  endsequence

  sequence s_quiet3;
    (!running && !toneRun)[*3];
  endsequence

  a_start_delay: assert property (s_idle_rise |=> !vibratorOut && !ledOut)
    else $error("output came up without idle delay");

  a_zero_halts: assert property (s_quiet3 |-> !vibratorOut && !ledOut && toneLowOeN)
    else $error("outputs active with no alert source");

  a_last_slot_irq: assert property (cadRun && slotTick && cadPos == 3'h1 |=> alertIrq)
    else $error("no interrupt at last slot start");

  a_std_timeout: assert property ($rose(stdDone) |-> alertIrq)
    else $error("no interrupt at standard alert end");

  a_auto_clear: assert property (stdEnd && autoFlag && !wrSetup && !callReceived
                                 |=> !setup[pag_pkg::SETUP_STD])
    else $error("auto alert did not clear standard bit");

  a_auto_load: assert property (callReceived && autoAlertEn |=> setup[pag_pkg::SETUP_STD]
                                && setup[7:6] == $past(callTypeCode))
    else $error("auto alert setup not loaded");

  a_counter_phase: assert property (!(toneHighOut && !toneLowOeN))
    else $error("tone outputs not in counter phase");

  a_vib_enable: assert property (!setup[pag_pkg::SETUP_VIB_EN] |=> !vibratorOut)
    else $error("vibrator driven while disabled");

  a_direct_led: assert property (directSync && runningQ && setup[pag_pkg::SETUP_LED_EN]
                                 && !setup[pag_pkg::SETUP_WARBLE] |=> ledOut)
    else $error("direct alert did not light LED");

  a_low_level: assert property (stdMode && !setup[pag_pkg::SETUP_LEVEL]
                                && stdSlotCnt < 9'(pag_pkg::STD_LOW_SLOTS)
                                |=> !toneHighOut)
    else $error("high tone in low part of standard alert");

endmodule : pag_alert_top

`default_nettype wire

// ---- bench/pag_transducer_model.sv ----
/*
  Transducer side of the alert generator: counts active cycles of each
  alert output inside a window that the bench opens and closes.
  Assumes one clock; the low tone pin is open drain with a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none

module pag_transducer_model (
  // Clock and window control
  input  wire logic clk,
  input  wire logic clear,
  input  wire logic measure,
  // Alert pins
  input  wire logic toneHighOut,
  input  wire logic toneLowOut,
  input  wire logic toneLowOeN,
  input  wire logic vibratorOut,
  input  wire logic ledOut,
  input  wire logic alertIrq,
  // Counts
  output var int    ledOn,
  output var int    vibOn,
  output var int    toneOn,
  output var int    lowOn,
  output var int    irqSeen,
  output var int    phaseBad
);
  // ==========================================================================
  // Pin level: the pull-up wins unless the stage sinks it
  wire logic lowPin = toneLowOeN ? 1'b1 : toneLowOut;

  // Counts grow only inside a window, so partial periods never leak in
  always @(posedge clk) begin
    if (clear) begin
      ledOn    <= 0;
      vibOn    <= 0;
      toneOn   <= 0;
      lowOn    <= 0;
      irqSeen  <= 0;
      phaseBad <= 0;
    end else if (measure) begin
      ledOn    <= ledOn + int'(ledOut);
      vibOn    <= vibOn + int'(vibratorOut);
      toneOn   <= toneOn + int'(toneHighOut);
      lowOn    <= lowOn + int'(!lowPin);
      irqSeen  <= irqSeen + int'(alertIrq);
      phaseBad <= phaseBad + int'(toneHighOut & !lowPin);
    end
  end

endmodule : pag_transducer_model

`default_nettype wire

// ---- bench/test_pager_alert_generator.sv ----
/*
  Self-checking bench for the alert generator: register tasks, counted
  output windows and a closing verdict.
  Assumes shortened slot and tone counts set on the instance below.
*/
`timescale 1ns/10ps
`default_nettype none

module test_pager_alert_generator;
  // ==========================================================================
  // Signals
  logic       clk, resetn, regWr, regRd, callReceived, autoAlertEn, directAlertIn;
  logic [7:0] regAddr, regWdata, regRdata, d;
  logic [2:0] pos;
  logic [1:0] callTypeCode;
  logic       toneHighOut, toneLowOut, toneLowOeN, vibratorOut, ledOut, alertIrq;
  logic       clear, measure;
  int         ledOn, vibOn, toneOn, lowOn, irqSeen, phaseBad;
  int         mismatches, comparisons, cycles, i;
  logic [7:0] setTab [6] = '{8'h00, 8'h10, 8'h12, 8'h20, 8'h22, 8'h24};
  int         ledTab [6] = '{0, 0, 0, 384, 384, 192};
  int         vibTab [6] = '{0, 192, 384, 0, 0, 0};
  logic [7:0] stdTab [4] = '{pag_pkg::STD_PATTERN_CT0, pag_pkg::STD_PATTERN_CT1,
                             pag_pkg::STD_PATTERN_CT2, pag_pkg::STD_PATTERN_CT3};

  // Short counts keep a 384-cycle window a whole number of every period
  pag_alert_top #(.SLOT_CYCLES(20'h10), .VIB_HALF(20'h4), .WARBLE_HALF(20'h6),
    .TONE_UPPER_HALF(20'h2), .TONE_LOWER_HALF(20'h3)) uut (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .callReceived(callReceived), .callTypeCode(callTypeCode),
    .autoAlertEn(autoAlertEn), .directAlertIn(directAlertIn),
    .toneHighOut(toneHighOut), .toneLowOut(toneLowOut), .toneLowOeN(toneLowOeN),
    .vibratorOut(vibratorOut), .ledOut(ledOut), .alertIrq(alertIrq));

  pag_transducer_model model (
    .clk(clk), .clear(clear), .measure(measure), .toneHighOut(toneHighOut),
    .toneLowOut(toneLowOut), .toneLowOeN(toneLowOeN), .vibratorOut(vibratorOut),
    .ledOut(ledOut), .alertIrq(alertIrq), .ledOn(ledOn), .vibOn(vibOn),
    .toneOn(toneOn), .lowOn(lowOn), .irqSeen(irqSeen), .phaseBad(phaseBad));

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
    // Spare edge, so a following write never drives the strobe twice at once
    @(posedge clk);
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    @(posedge clk);
    v = regRdata;
  endtask : rd

  // Settle first, so the idle activation delay does not eat counts
  task automatic win();
    repeat (8) @(posedge clk);
    clear   <= 1'b1;
    @(posedge clk);
    clear   <= 1'b0;
    measure <= 1'b1;
    repeat (384) @(posedge clk);
    measure <= 1'b0;
    @(posedge clk);
  endtask : win

  task automatic waitIrq(input int n);
    for (int k = 0; k < n && alertIrq !== 1'b1; k++) @(posedge clk);
    chk(alertIrq, 1);
  endtask : waitIrq

  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // ==========================================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {resetn, regWr, regRd, callReceived, autoAlertEn, directAlertIn} = 6'h00;
    {regAddr, regWdata, callTypeCode, clear, measure} = 20'h00000;
    mismatches  = 0;
    comparisons = 0;
    cycles      = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk({toneHighOut, toneLowOut, toneLowOeN, vibratorOut, ledOut, alertIrq}, 6'h08);
    rd(8'h0B, d); chk(d, 8'h70);
    rd(8'h04, d); chk(d, 8'h00);
    rd(8'h55, d); chk(d, 8'h00);
    $display("test reset done");
    wr(8'h04, 8'h20); wr(8'h03, 8'h80); win();
    chk(ledOn, 48);
    chk(irqSeen, 3);
    wr(8'h03, 8'h01); waitIrq(200);
    repeat (3) @(posedge clk); chk(ledOut, 1);
    rd(8'h0B, d); chk(d[0], 1);
    wr(8'h03, 8'h00); win();
    chk(ledOn + irqSeen, 0);
    $display("test cadence done");
    wr(8'h03, 8'hFF);
    for (i = 0; i < 6; i++) begin
      wr(8'h04, setTab[i]); win();
      chk(ledOn, ledTab[i]);
      chk(vibOn, vibTab[i]);
      chk(toneOn + lowOn, 0);
    end
    wr(8'h04, 8'h08); win();
    chk({toneOn == 0, lowOn > 0}, 2'h3);
    wr(8'h04, 8'h0A); win();
    chk({toneOn > 0, lowOn > 0, phaseBad != 0}, 3'h6);
    $display("test enables done");
    // High level: steady vibrator, so a single sample cannot land in an off half
    wr(8'h03, 8'h00); wr(8'h04, 8'h3A);
    directAlertIn <= 1'b1; repeat (8) @(posedge clk);
    chk({vibratorOut, ledOut}, 2'h3);
    directAlertIn <= 1'b0; repeat (16) @(posedge clk);
    chk({toneHighOut, toneLowOeN, vibratorOut, ledOut}, 4'h4);
    $display("test direct done");
    // Cadence left running underneath, to be paused by the standard alerts
    wr(8'h03, 8'h0F);
    for (i = 0; i < 4; i++) begin
      wr(8'h04, {i[1:0], 6'h31}); win();
      chk(ledOn, 48 * $countones(stdTab[i]));
      chk(vibOn, 192);
    end
    wr(8'h04, 8'h00); repeat (4) @(posedge clk);
    chk({vibratorOut, ledOut}, 2'h0);
    $display("test standard done");
    autoAlertEn <= 1'b1; callTypeCode <= 2'h2; callReceived <= 1'b1;
    @(posedge clk);
    callReceived <= 1'b0;
    rd(8'h0B, d); chk(d[3:2], 2'h3);
    pos = d[6:4];
    win();
    chk({toneOn == 0, lowOn > 0}, 2'h3);
    repeat (800) @(posedge clk); win();
    chk(toneOn > 0, 1);
    waitIrq(3000);
    rd(8'h0B, d); chk(d[3:1], 3'h1);
    chk(d[6:4], pos);
    $display("test automatic done");
    test_done();
  end

endmodule : test_pager_alert_generator

`default_nettype wire
